// [common/irq_prio_pkg.sv]
package irq_prio_pkg;

	// ==========================================================
	// Bus and register geometry
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int NUM_REGS = 4;
	localparam int FIELD_W = 2;
	localparam int NUM_LEVELS = 4;

	localparam logic [ADDR_W-1:0] REG_DEBUG_BREAK_STEP = 4'h0;
	localparam logic [ADDR_W-1:0] REG_DEBUG_COMM_TRACE = 4'h1;
	localparam logic [ADDR_W-1:0] REG_SYSTEM_SOURCE = 4'h2;
	localparam logic [ADDR_W-1:0] REG_PORT_CAN_SOURCE = 4'h3;

	localparam logic [DATA_W-1:0] REG_RESET_VAL = 16'h0000;

	// Writable bits per register, index 0 in the low word.
	localparam logic [NUM_REGS-1:0][DATA_W-1:0] WR_MASK = {
		16'hfffc, 16'hffcf, 16'h003f, 16'h3c00};

	// ==========================================================
	// Field codes
	localparam logic [FIELD_W-1:0] CODE_OFF = 2'h0;
	localparam logic [FIELD_W-1:0] CODE_STEP = 2'h1;
	localparam logic [FIELD_W-1:0] LEVEL_ZERO = 2'h0;
	localparam logic [FIELD_W-1:0] LEVEL_TOP = 2'h3;

	// ==========================================================
	// Source table: the debug sources come first.
	localparam int NUM_SRC = 19;
	localparam int NUM_DEBUG = 5;
	localparam int SRC_W = 5;

	localparam int SRC_BREAKPOINT = 0;
	localparam int SRC_STEP_COUNTER = 1;
	localparam int SRC_RX_FULL = 2;
	localparam int SRC_TX_EMPTY = 3;
	localparam int SRC_TRACE_BUFFER = 4;
	localparam int SRC_FLASH_BUF_EMPTY = 5;
	localparam int SRC_FLASH_CMD_DONE = 6;
	localparam int SRC_FLASH_ERROR = 7;
	localparam int SRC_PLL_LOCK = 8;
	localparam int SRC_LOW_VOLTAGE = 9;
	localparam int SRC_EXT_REQUEST_B = 10;
	localparam int SRC_EXT_REQUEST_A = 11;
	localparam int SRC_PORT_D = 12;
	localparam int SRC_PORT_E = 13;
	localparam int SRC_PORT_F = 14;
	localparam int SRC_CAN_MSG_BUFFER = 15;
	localparam int SRC_CAN_WAKE = 16;
	localparam int SRC_CAN_ERROR = 17;
	localparam int SRC_CAN_BUS_OFF = 18;

	localparam int SRC_REG [NUM_SRC] = '{
		0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
	localparam int SRC_LSB [NUM_SRC] = '{
		12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2};

endpackage : irq_prio_pkg

// [common/prio_src_if.sv]
interface prio_src_if;
	logic [irq_prio_pkg::NUM_SRC-1:0][irq_prio_pkg::FIELD_W-1:0] field;
	logic [irq_prio_pkg::NUM_SRC-1:0] en;
	logic [irq_prio_pkg::NUM_SRC-1:0][irq_prio_pkg::FIELD_W-1:0] lvl;

	modport regs (output field, input en, input lvl);
	modport dec (input field, output en, output lvl);
endinterface : prio_src_if

// [hw/prio_level_decode.sv]
module prio_level_decode (
	prio_src_if.dec src
);

	// ==========================================================
	// Per-source decode
	for (genvar i = 0; i < irq_prio_pkg::NUM_SRC; i++) begin : g_src
		assign src.en[i] = (src.field[i] != irq_prio_pkg::CODE_OFF);
		if (i < irq_prio_pkg::NUM_DEBUG) begin : g_debug
			assign src.lvl[i] = src.field[i];
		end else begin : g_general
			// Disabled fields would wrap to the top level, so they are forced low.
			assign src.lvl[i] = src.en[i] ?
				irq_prio_pkg::FIELD_W'(src.field[i] - irq_prio_pkg::CODE_STEP) :
				irq_prio_pkg::LEVEL_ZERO;
		end
	end

endmodule : prio_level_decode

// [hw/irq_priority_level_regs.sv]
// Overview of operation
// - A debug source field decodes 00 as off and 01, 10, 11 as levels 1, 2 and 3.
// - Every other source field decodes 00 as off and 01, 10, 11 as levels 0, 1 and 2.
// - Reserved bits read as zero and ignore writes.
// - Reset clears every field, so every source starts disabled.
// - Register 0 holds breakpoint in bits 13:12 and step counter in bits 11:10.
// - Register 1 holds receive full in 5:4, transmit empty in 3:2 and trace in 1:0.
// - Register 2 holds the three flash levels in bits 15:14, 13:12 and 11:10.
// - Register 2 holds the clock loss-of-lock level in bits 9:8.
// - Register 2 holds the low-voltage level in bits 7:6 and reserves bits 5:4.
// - Register 2 holds external request B in bits 3:2 and request A in bits 1:0.
// - Register 3 holds ports D, E and F in bits 15:14, 13:12 and 11:10.
// - Register 3 holds CAN message, wake-up and error levels in 9:8, 7:6 and 5:4.
module irq_priority_level_regs (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Register port
	input wire logic [irq_prio_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [irq_prio_pkg::DATA_W-1:0] reg_wr_data_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [irq_prio_pkg::DATA_W-1:0] reg_rd_data_out,
	// Source requests from the peripherals
	input wire logic [irq_prio_pkg::NUM_SRC-1:0] src_req_in,
	// Toward the arbitration logic
	output logic [irq_prio_pkg::NUM_SRC-1:0] src_en_out,
	output logic [irq_prio_pkg::NUM_SRC-1:0][irq_prio_pkg::FIELD_W-1:0] src_level_out,
	output logic [irq_prio_pkg::NUM_SRC-1:0] src_req_out,
	output logic [irq_prio_pkg::NUM_LEVELS-1:0] level_req_out,
	output logic any_req_out,
	output logic [irq_prio_pkg::FIELD_W-1:0] top_level_out,
	output logic [irq_prio_pkg::SRC_W-1:0] top_src_out
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [irq_prio_pkg::NUM_REGS-1:0][irq_prio_pkg::DATA_W-1:0] regs;
		logic [irq_prio_pkg::DATA_W-1:0] rd_data;
		logic [irq_prio_pkg::NUM_SRC-1:0] en;
		logic [irq_prio_pkg::NUM_SRC-1:0][irq_prio_pkg::FIELD_W-1:0] lvl;
		logic [irq_prio_pkg::NUM_SRC-1:0] req;
		logic [irq_prio_pkg::NUM_LEVELS-1:0] level_req;
		logic any_req;
		logic [irq_prio_pkg::FIELD_W-1:0] top_level;
		logic [irq_prio_pkg::SRC_W-1:0] top_src;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	prio_src_if src ();

	prio_level_decode u_decode (
		.src(src.dec)
	);

	// ==========================================================
	// Field extraction
	for (genvar i = 0; i < irq_prio_pkg::NUM_SRC; i++) begin : g_field
		assign src.field[i] = state_ff.regs[irq_prio_pkg::SRC_REG[i]]
			[irq_prio_pkg::SRC_LSB[i] +: irq_prio_pkg::FIELD_W];
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic [irq_prio_pkg::NUM_SRC-1:0] gated;
		gated = src_req_in & src.en;
		nxt_state = state_ff;
		nxt_state.rd_data = '0;
		for (int r = 0; r < irq_prio_pkg::NUM_REGS; r++) begin
			if (reg_wr_in && (reg_addr_in == irq_prio_pkg::ADDR_W'(r))) begin
				// Only field bits take the write; reserved bits stay zero.
				nxt_state.regs[r] = (state_ff.regs[r] & ~irq_prio_pkg::WR_MASK[r]) |
					(reg_wr_data_in & irq_prio_pkg::WR_MASK[r]);
			end
			if (reg_rd_in && (reg_addr_in == irq_prio_pkg::ADDR_W'(r))) begin
				nxt_state.rd_data = state_ff.regs[r] & irq_prio_pkg::WR_MASK[r];
			end
		end
		nxt_state.en = src.en;
		nxt_state.lvl = src.lvl;
		nxt_state.req = gated;
		nxt_state.level_req = '0;
		nxt_state.top_level = irq_prio_pkg::LEVEL_ZERO;
		nxt_state.top_src = '0;
		// Higher levels overwrite lower ones; within a level the lowest index wins.
		for (int k = 0; k < irq_prio_pkg::NUM_LEVELS; k++) begin
			for (int i = irq_prio_pkg::NUM_SRC - 1; i >= 0; i--) begin
				if (gated[i] && (src.lvl[i] == irq_prio_pkg::FIELD_W'(k))) begin
					nxt_state.level_req[k] = 1'b1;
					nxt_state.top_level = irq_prio_pkg::FIELD_W'(k);
					nxt_state.top_src = irq_prio_pkg::SRC_W'(i);
				end
			end
		end
		nxt_state.any_req = |gated;
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rd_data_out = state_ff.rd_data;
	assign src_en_out = state_ff.en;
	assign src_level_out = state_ff.lvl;
	assign src_req_out = state_ff.req;
	assign level_req_out = state_ff.level_req;
	assign any_req_out = state_ff.any_req;
	assign top_level_out = state_ff.top_level;
	assign top_src_out = state_ff.top_src;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	property p_debug_level;
		src_en_out[irq_prio_pkg::SRC_BREAKPOINT] |->
			(src_level_out[irq_prio_pkg::SRC_BREAKPOINT] ==
			$past(src.field[irq_prio_pkg::SRC_BREAKPOINT])) &&
			(src_level_out[irq_prio_pkg::SRC_BREAKPOINT] != irq_prio_pkg::LEVEL_ZERO);
	endproperty
	a_debug_level: assert property (p_debug_level)
		else $error("debug source level mismatch");

	property p_general_level;
		src_en_out[irq_prio_pkg::SRC_LOW_VOLTAGE] |->
			(src_level_out[irq_prio_pkg::SRC_LOW_VOLTAGE] ==
			irq_prio_pkg::FIELD_W'($past(src.field[irq_prio_pkg::SRC_LOW_VOLTAGE]) -
			irq_prio_pkg::CODE_STEP)) &&
			(src_level_out[irq_prio_pkg::SRC_LOW_VOLTAGE] != irq_prio_pkg::LEVEL_TOP);
	endproperty
	a_general_level: assert property (p_general_level)
		else $error("general source level mismatch");

	property p_reserved_read;
		reg_rd_in && (reg_addr_in == irq_prio_pkg::REG_DEBUG_BREAK_STEP) |=>
			((reg_rd_data_out & ~irq_prio_pkg::WR_MASK[0]) == '0);
	endproperty
	a_reserved_read: assert property (p_reserved_read)
		else $error("reserved bits of register 0 read nonzero");

	property p_reserved_write;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_PORT_CAN_SOURCE) |=>
			(state_ff.regs[3] == ($past(reg_wr_data_in) & irq_prio_pkg::WR_MASK[3]));
	endproperty
	a_reserved_write: assert property (p_reserved_write)
		else $error("register 3 did not take masked write");

	property p_reset_clear;
		$fell(sys_rst_in) |-> (state_ff.regs == '0) && (src_en_out == '0) &&
			(src_req_out == '0);
	endproperty
	a_reset_clear: assert property (@(posedge sys_clk_in) p_reset_clear)
		else $error("fields not cleared by reset");

	property p_reg0_fields;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_DEBUG_BREAK_STEP) |=>
			(src.field[irq_prio_pkg::SRC_BREAKPOINT] == $past(reg_wr_data_in[13:12])) &&
			(src.field[irq_prio_pkg::SRC_STEP_COUNTER] == $past(reg_wr_data_in[11:10]));
	endproperty
	a_reg0_fields: assert property (p_reg0_fields)
		else $error("register 0 field placement wrong");

	property p_reg1_fields;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_DEBUG_COMM_TRACE) |=>
			(src.field[irq_prio_pkg::SRC_RX_FULL] == $past(reg_wr_data_in[5:4])) &&
			(src.field[irq_prio_pkg::SRC_TX_EMPTY] == $past(reg_wr_data_in[3:2])) &&
			(src.field[irq_prio_pkg::SRC_TRACE_BUFFER] == $past(reg_wr_data_in[1:0])) &&
			(state_ff.regs[1][15:6] == '0);
	endproperty
	a_reg1_fields: assert property (p_reg1_fields)
		else $error("register 1 field placement wrong");

	property p_flash_enable;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_SYSTEM_SOURCE) && !reg_rd_in ##1
			!(reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_SYSTEM_SOURCE)) |=>
			(src_en_out[irq_prio_pkg::SRC_FLASH_BUF_EMPTY] ==
			($past(reg_wr_data_in[15:14], 2) != irq_prio_pkg::CODE_OFF)) &&
			(src_en_out[irq_prio_pkg::SRC_FLASH_CMD_DONE] ==
			($past(reg_wr_data_in[13:12], 2) != irq_prio_pkg::CODE_OFF)) &&
			(src_en_out[irq_prio_pkg::SRC_FLASH_ERROR] ==
			($past(reg_wr_data_in[11:10], 2) != irq_prio_pkg::CODE_OFF));
	endproperty
	a_flash_enable: assert property (p_flash_enable)
		else $error("flash source enables do not follow write");

	property p_lock_field;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_SYSTEM_SOURCE) |=>
			(src.field[irq_prio_pkg::SRC_PLL_LOCK] == $past(reg_wr_data_in[9:8]));
	endproperty
	a_lock_field: assert property (p_lock_field)
		else $error("loss-of-lock field placement wrong");

	property p_lvi_field;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_SYSTEM_SOURCE) |=>
			(src.field[irq_prio_pkg::SRC_LOW_VOLTAGE] == $past(reg_wr_data_in[7:6])) &&
			(state_ff.regs[2][5:4] == '0);
	endproperty
	a_lvi_field: assert property (p_lvi_field)
		else $error("low-voltage field or reserved bits wrong");

	property p_ext_fields;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_SYSTEM_SOURCE) |=>
			(src.field[irq_prio_pkg::SRC_EXT_REQUEST_B] == $past(reg_wr_data_in[3:2])) &&
			(src.field[irq_prio_pkg::SRC_EXT_REQUEST_A] == $past(reg_wr_data_in[1:0]));
	endproperty
	a_ext_fields: assert property (p_ext_fields)
		else $error("external request field placement wrong");

	property p_port_fields;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_PORT_CAN_SOURCE) |=>
			(src.field[irq_prio_pkg::SRC_PORT_D] == $past(reg_wr_data_in[15:14])) &&
			(src.field[irq_prio_pkg::SRC_PORT_E] == $past(reg_wr_data_in[13:12])) &&
			(src.field[irq_prio_pkg::SRC_PORT_F] == $past(reg_wr_data_in[11:10]));
	endproperty
	a_port_fields: assert property (p_port_fields)
		else $error("port field placement wrong");

	property p_can_fields;
		reg_wr_in && (reg_addr_in == irq_prio_pkg::REG_PORT_CAN_SOURCE) |=>
			(src.field[irq_prio_pkg::SRC_CAN_MSG_BUFFER] == $past(reg_wr_data_in[9:8])) &&
			(src.field[irq_prio_pkg::SRC_CAN_WAKE] == $past(reg_wr_data_in[7:6])) &&
			(src.field[irq_prio_pkg::SRC_CAN_ERROR] == $past(reg_wr_data_in[5:4]));
	endproperty
	a_can_fields: assert property (p_can_fields)
		else $error("CAN field placement wrong");

	property p_req_gated;
		((src_req_out & ~src_en_out) == '0) &&
			(src_req_out == ($past(src_req_in) & src_en_out)) &&
			(any_req_out == (src_req_out != '0));
	endproperty
	a_req_gated: assert property (p_req_gated)
		else $error("request forwarded from disabled source");

	property p_top_level;
		any_req_out |-> level_req_out[top_level_out] && src_req_out[top_src_out] &&
			(src_level_out[top_src_out] == top_level_out);
	endproperty
	a_top_level: assert property (p_top_level)
		else $error("top request does not match its source");

	property p_top_highest;
		any_req_out |-> ((level_req_out >> top_level_out) == irq_prio_pkg::NUM_LEVELS'(1));
	endproperty
	a_top_highest: assert property (p_top_highest)
		else $error("a higher level request was passed over");

	property p_idle_quiet;
		!any_req_out |-> (level_req_out == '0) && (src_req_out == '0) &&
			(top_level_out == irq_prio_pkg::LEVEL_ZERO) && (top_src_out == '0);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("arbitration outputs active with no request");

	// Read data stand for one cycle only, so a stale word cannot be taken twice.
	property p_rd_idle;
		!reg_rd_in |=> (reg_rd_data_out == '0);
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data stand without a read");

	property p_unmapped_write;
		reg_wr_in && (reg_addr_in >= irq_prio_pkg::ADDR_W'(irq_prio_pkg::NUM_REGS)) |=>
			(state_ff.regs == $past(state_ff.regs));
	endproperty
	a_unmapped_write: assert property (p_unmapped_write)
		else $error("write to an unmapped index changed a register");

	// ==========================================================
	// Per-source checks
	// One copy per source, so a wrong enable or level decode of a source points at its index.
	for (genvar i = 0; i < irq_prio_pkg::NUM_SRC; i++) begin : g_src_chk
		if (i < irq_prio_pkg::NUM_DEBUG) begin : g_debug
			property p_debug_range;
				src_en_out[i] |-> (src_level_out[i] != irq_prio_pkg::LEVEL_ZERO);
			endproperty
			a_debug_range: assert property (p_debug_range)
				else $error("enabled debug source shows level zero");
		end else begin : g_general
			property p_general_range;
				src_en_out[i] |-> (src_level_out[i] != irq_prio_pkg::LEVEL_TOP);
			endproperty
			a_general_range: assert property (p_general_range)
				else $error("enabled general source shows the top level");
		end

		property p_off_silent;
			!src_en_out[i] |-> !src_req_out[i] &&
				(src_level_out[i] == irq_prio_pkg::LEVEL_ZERO);
		endproperty
		a_off_silent: assert property (p_off_silent)
			else $error("disabled source requests or shows a level");

		property p_en_follows_field;
			src_en_out[i] == ($past(src.field[i]) != irq_prio_pkg::CODE_OFF);
		endproperty
		a_en_follows_field: assert property (p_en_follows_field)
			else $error("source enable does not follow its field");
	end

	// ==========================================================
	// Per-register checks
	for (genvar r = 0; r < irq_prio_pkg::NUM_REGS; r++) begin : g_reg_chk
		property p_reserved_zero;
			(state_ff.regs[r] & ~irq_prio_pkg::WR_MASK[r]) == '0;
		endproperty
		a_reserved_zero: assert property (p_reserved_zero)
			else $error("reserved register bit holds a one");

		property p_write_lands;
			reg_wr_in && (reg_addr_in == irq_prio_pkg::ADDR_W'(r)) |=>
				(state_ff.regs[r] == ($past(reg_wr_data_in) & irq_prio_pkg::WR_MASK[r]));
		endproperty
		a_write_lands: assert property (p_write_lands)
			else $error("register did not take the masked write");

		property p_read_back;
			reg_rd_in && (reg_addr_in == irq_prio_pkg::ADDR_W'(r)) |=>
				(reg_rd_data_out == $past(state_ff.regs[r]));
		endproperty
		a_read_back: assert property (p_read_back)
			else $error("read data differ from the register");
	end

	c_debug_top: cover property (any_req_out && (top_level_out == irq_prio_pkg::LEVEL_TOP));
	c_general_zero: cover property (src_req_out[irq_prio_pkg::SRC_PORT_D] &&
		(src_level_out[irq_prio_pkg::SRC_PORT_D] == irq_prio_pkg::LEVEL_ZERO));
	c_blocked: cover property (src_req_in[irq_prio_pkg::SRC_TX_EMPTY] ##1
		!src_en_out[irq_prio_pkg::SRC_TX_EMPTY]);
	c_write_read: cover property (reg_wr_in ##1 reg_rd_in ##1 (reg_rd_data_out != '0));

endmodule : irq_priority_level_regs

// [tb/irq_src_model.sv]
// ==========================================================
// Peripheral request sources
// Requests are levels that change only just after a rising edge, the way
// on-chip peripherals hold an interrupt line until software clears it.
module irq_src_model (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Sources the bench wants raised
	input wire logic [irq_prio_pkg::NUM_SRC-1:0] want_in,
	// Toward the priority block
	output logic [irq_prio_pkg::NUM_SRC-1:0] req_out
);
	timeunit 1ns;
	timeprecision 1ps;

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			req_out <= '0;
		end else begin
			req_out <= want_in;
		end
	end
endmodule : irq_src_model

// [tb/irq_priority_level_regs_tb_top.sv]
module irq_priority_level_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

	typedef struct packed {
		logic [irq_prio_pkg::ADDR_W-1:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
	} row_t;

	logic sys_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [irq_prio_pkg::ADDR_W-1:0] reg_addr_in = '0;
	logic [15:0] reg_wr_data_in = '0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [15:0] reg_rd_data_out;
	logic [18:0] want = '0;
	logic [18:0] src_req_in;
	logic [18:0] src_en_out;
	logic [18:0][1:0] src_level_out;
	logic [18:0] src_req_out;
	logic [3:0] level_req_out;
	logic any_req_out;
	logic [1:0] top_level_out;
	logic [4:0] top_src_out;
	int n_errors = 0;
	int n_compared = 0;
	logic [15:0] d;
	logic [1:0] cv;

	// Reserved bits and unmapped places must come back as zero.
	row_t rows [8] = '{
		'{4'h0, 16'hffff, 16'h3c00}, '{4'h1, 16'hffff, 16'h003f},
		'{4'h2, 16'hffff, 16'hffcf}, '{4'h3, 16'hffff, 16'hfffc},
		'{4'h4, 16'hffff, 16'h0000}, '{4'hf, 16'hffff, 16'h0000},
		'{4'h0, 16'hc3ff, 16'h0000}, '{4'h2, 16'h0030, 16'h0000}};
	int fld_lsb [19] = '{12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2};

	always #5 sys_clk_in = ~sys_clk_in;

	irq_src_model u_src (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.want_in(want),
		.req_out(src_req_in)
	);

	irq_priority_level_regs DUT (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.reg_addr_in(reg_addr_in),
		.reg_wr_data_in(reg_wr_data_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rd_data_out(reg_rd_data_out),
		.src_req_in(src_req_in),
		.src_en_out(src_en_out),
		.src_level_out(src_level_out),
		.src_req_out(src_req_out),
		.level_req_out(level_req_out),
		.any_req_out(any_req_out),
		.top_level_out(top_level_out),
		.top_src_out(top_src_out)
	);

	function automatic int fld_reg(input int i);
		return (i < 2) ? 0 : (i < 5) ? 1 : (i < 12) ? 2 : 3;
	endfunction : fld_reg

	// Debug sources sit one level above the others for the same code.
	function automatic logic [1:0] exp_lvl(input int i, input logic [1:0] f);
		if (f == 2'h0) return 2'h0;
		return (i < 5) ? f : f - 2'h1;
	endfunction : exp_lvl

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wr_data_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		v = reg_rd_data_out;
	endtask : rd

	task automatic settle();
		repeat (2) @(posedge sys_clk_in);
		#1;
	endtask : settle

	task automatic wrap_up();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge sys_clk_in);
		n_errors++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		for (int r = 0; r < 4; r++) begin
			rd(4'(r), d);
			`CHK(d, 16'h0000)
		end
		`CHK(src_en_out, 19'h0)
		foreach (rows[k]) begin
			wr(rows[k].addr, rows[k].wdata);
			rd(rows[k].addr, d);
			`CHK(d, rows[k].rdata)
		end
		// Every code in every field at once.
		for (int c = 0; c < 4; c++) begin
			cv = c[1:0];
			for (int r = 0; r < 4; r++) wr(4'(r), {8{cv}});
			settle();
			for (int i = 0; i < 19; i++) begin
				`CHK(src_en_out[i], cv != 2'h0)
				`CHK(src_level_out[i], exp_lvl(i, cv))
			end
		end
		for (int r = 0; r < 4; r++) wr(4'(r), 16'h0000);
		// One field at a time proves its bit position.
		for (int i = 0; i < 19; i++) begin
			wr(4'(fld_reg(i)), 16'h0002 << fld_lsb[i]);
			settle();
			`CHK(src_en_out, 19'h1 << i)
			`CHK(src_level_out[i], exp_lvl(i, 2'h2))
			wr(4'(fld_reg(i)), 16'h0000);
		end
		// Arbitration view: a debug and a port source both requesting.
		for (int r = 0; r < 4; r++) wr(4'(r), 16'hffff);
		want <= (19'h1 << 12) | (19'h1 << 3);
		repeat (3) @(posedge sys_clk_in);
		#1;
		`CHK(src_req_out, 19'h01008)
		`CHK(level_req_out, 4'hc)
		`CHK({any_req_out, top_level_out, top_src_out}, {1'b1, 2'h3, 5'h03})
		wr(4'h1, 16'h0000);
		settle();
		`CHK(src_req_out, 19'h01000)
		`CHK({level_req_out, top_level_out, top_src_out}, {4'h4, 2'h2, 5'h0c})
		wr(4'h3, 16'h4000);
		settle();
		`CHK({level_req_out, top_level_out, top_src_out}, {4'h1, 2'h0, 5'h0c})
		// A write then a read with no idle cycle between them.
		@(posedge sys_clk_in);
		reg_addr_in <= irq_prio_pkg::REG_SYSTEM_SOURCE;
		reg_wr_data_in <= 16'h0040;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		`CHK(reg_rd_data_out, 16'h0040)
		@(posedge sys_clk_in);
		#1;
		`CHK(reg_rd_data_out, 16'h0000)
		`CHK({src_en_out[9], src_level_out[9]}, 3'h4)
		// Reset in mid-run with requests still raised.
		@(posedge sys_clk_in);
		sys_rst_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		rd(4'h3, d);
		`CHK(d, 16'h0000)
		settle();
		`CHK({src_en_out, src_req_out, any_req_out}, 39'h0)
		wrap_up();
	end
endmodule : irq_priority_level_regs_tb_top
